/* hdl/uoef_event_flags.sv */
// OTG event and link error flag logic with an Avalon-MM register slave.
// Assumes all pin and link inputs are synchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module uoef_event_flags
  import uoef_pkg::*;
#(
  parameter int MS_CYC = UOEF_MS_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Avalon-MM register slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Cable side levels
  input wire uoef_pins_t pins,
  // Packet engine and DMA events
  input wire uoef_link_t link,
  // Mode outputs and interrupt
  output logic host_mode,
  output logic suspend_req,
  output logic irq
);

  localparam int MSW = $clog2(MS_CYC + 1);
  localparam int IDW = $clog2(UOEF_IDLE_BIT_TIMES + 1);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYC - 1);
  localparam logic [IDW-1:0] IDLE_LIM = IDW'(UOEF_IDLE_BIT_TIMES);

  // All state of the block apart from the flags, which the two flag banks hold
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic primed;
    uoef_pins_t prev;
    logic [MSW-1:0] ms_cnt;
    logic [MSW-1:0] settle_cnt;
    logic [1:0] ls_stable;
    logic [7:0] otg_mask;
    logic [7:0] err_mask;
    logic [7:0] ctrl;
    logic [IDW-1:0] idle_cnt;
    logic idle_armed;
  } uoef_state_t;

  uoef_state_t q_reg;
  uoef_state_t q_next;

  logic req;
  logic wr_go;
  logic lane0;
  logic [7:0] wbyte;
  logic [7:0] otg_set;
  logic [7:0] err_set;
  logic [7:0] otg_flags;
  logic [7:0] err_flags;
  logic otg_irq;
  logic err_irq;
  logic otg_clr_we;
  logic err_clr_we;
  logic [1:0] ls_now;
  logic ls_moved;
  logic ms_tick;
  logic settle_hit;
  logic tmo_hit;

  // Bus request decode
  assign req = avs_read | avs_write;
  assign wr_go = avs_write & q_reg.ack;
  assign lane0 = avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];
  assign otg_clr_we = wr_go & lane0 & (avs_address == UOEF_OFF_OTG_STAT);
  assign err_clr_we = wr_go & lane0 & (avs_address == UOEF_OFF_ERR_STAT);

  // Line state and its change
  assign ls_now = {pins.dp, pins.dm};
  assign ls_moved = ls_now != {q_reg.prev.dp, q_reg.prev.dm};

  // Free running millisecond timer
  assign ms_tick = q_reg.ms_cnt == MS_LAST;

  // Line held still for a full millisecond
  assign settle_hit = !ls_moved && (q_reg.settle_cnt == MS_LAST);

  // Idle count passes the limit on this bit tick
  assign tmo_hit = q_reg.idle_armed && link.resp_wait && link.bit_tick
                   && (q_reg.idle_cnt == IDLE_LIM);

  // Event sources for the OTG status bank
  always_comb begin
    otg_set = 8'h00;
    if (q_reg.primed) begin
      otg_set[UOEF_ID_BIT] = pins.id != q_reg.prev.id;
      otg_set[UOEF_SESVD_BIT] = pins.sess_end & ~q_reg.prev.sess_end;
      otg_set[UOEF_BVBUS_BIT] = pins.sess_end != q_reg.prev.sess_end;
      otg_set[UOEF_AVBUS_BIT] = pins.sess_vld != q_reg.prev.sess_vld;
      otg_set[UOEF_ACT_BIT] = q_reg.ctrl[UOEF_SUSP_BIT]
                              && (ls_moved || pins.id != q_reg.prev.id
                              || pins.sess_vld != q_reg.prev.sess_vld);
    end
    otg_set[UOEF_MS_BIT] = ms_tick;
    otg_set[UOEF_LSTATE_BIT] = settle_hit && (ls_now != q_reg.ls_stable);
  end

  // Event sources for the error status bank
  always_comb begin
    err_set = 8'h00;
    err_set[UOEF_PID_BIT] = link.pid_bad;
    if (q_reg.ctrl[UOEF_HOST_BIT]) begin
      err_set[UOEF_CRC_EOF_BIT] = link.sof_zero & link.xfer_busy;
    end else begin
      err_set[UOEF_CRC_EOF_BIT] = link.crc5_bad;
    end
    err_set[UOEF_DMA_BIT] = link.dma_ovf | link.dma_unf | link.rx_trunc;
    err_set[UOEF_TMO_BIT] = tmo_hit;
  end

  // OTG event flags
  uoef_flag_bank #(
    .IMPL(UOEF_OTG_IMPL)
  ) u_otg_bank (
    .clk(ref_clk),
    .rstn(rstn),
    .set_in(otg_set),
    .clr_we(otg_clr_we),
    .clr_data(wbyte),
    .mask(q_reg.otg_mask),
    .flags(otg_flags),
    .irq(otg_irq)
  );

  // Link error flags
  uoef_flag_bank #(
    .IMPL(UOEF_ERR_IMPL)
  ) u_err_bank (
    .clk(ref_clk),
    .rstn(rstn),
    .set_in(err_set),
    .clr_we(err_clr_we),
    .clr_data(wbyte),
    .mask(q_reg.err_mask),
    .flags(err_flags),
    .irq(err_irq)
  );

  // Next state of the block
  always_comb begin
    q_next = q_reg;

    // Answer one cycle after the request is seen
    q_next.ack = req & ~q_reg.ack;

    // Read data captured while waitrequest is high
    if (avs_read && !q_reg.ack) begin
      case (avs_address)
        UOEF_OFF_OTG_STAT: begin
          q_next.rdata = {24'h000000, otg_flags};
        end
        UOEF_OFF_OTG_MASK: begin
          q_next.rdata = {24'h000000, q_reg.otg_mask};
        end
        UOEF_OFF_ERR_STAT: begin
          q_next.rdata = {24'h000000, err_flags};
        end
        UOEF_OFF_ERR_MASK: begin
          q_next.rdata = {24'h000000, q_reg.err_mask};
        end
        UOEF_OFF_CTRL: begin
          q_next.rdata = {24'h000000, q_reg.ctrl};
        end
        UOEF_OFF_LINE: begin
          q_next.rdata = {24'h000000, 1'b0, q_reg.ls_stable, pins};
        end
        default: begin
          q_next.rdata = 32'h00000000;
        end
      endcase
    end

    // Register writes on the accepting edge
    if (wr_go && lane0) begin
      case (avs_address)
        UOEF_OFF_OTG_MASK: begin
          q_next.otg_mask = wbyte & UOEF_OTG_IMPL;
        end
        UOEF_OFF_ERR_MASK: begin
          q_next.err_mask = wbyte & UOEF_ERR_IMPL;
        end
        UOEF_OFF_CTRL: begin
          q_next.ctrl = wbyte & UOEF_CTRL_IMPL;
        end
        default: begin
          q_next.ctrl = q_reg.ctrl;
        end
      endcase
    end

    // Pin history; edges count only after the first sample
    q_next.prev = pins;
    q_next.primed = 1'b1;

    // Millisecond timer wraps
    if (ms_tick) begin
      q_next.ms_cnt = '0;
    end else begin
      q_next.ms_cnt = q_reg.ms_cnt + MSW'(1);
    end

    // Settling counter restarts on any line change
    if (ls_moved) begin
      q_next.settle_cnt = '0;
    end else if (settle_hit) begin
      q_next.settle_cnt = q_reg.settle_cnt;
      q_next.ls_stable = ls_now;
    end else begin
      q_next.settle_cnt = q_reg.settle_cnt + MSW'(1);
    end

    // Idle time since the last end of packet
    if (link.eop) begin
      q_next.idle_cnt = '0;
      q_next.idle_armed = link.resp_wait;
    end else if (!link.resp_wait || tmo_hit) begin
      q_next.idle_armed = 1'b0;
    end else if (q_reg.idle_armed && link.bit_tick) begin
      q_next.idle_cnt = q_reg.idle_cnt + IDW'(1);
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q_reg.ack <= 1'b0;
      q_reg.rdata <= 32'h00000000;
      q_reg.primed <= 1'b0;
      q_reg.prev <= '0;
      q_reg.ms_cnt <= '0;
      q_reg.settle_cnt <= '0;
      q_reg.ls_stable <= UOEF_LS_RST;
      q_reg.otg_mask <= UOEF_MASK_RST;
      q_reg.err_mask <= UOEF_MASK_RST;
      q_reg.ctrl <= UOEF_CTRL_RST;
      q_reg.idle_cnt <= '0;
      q_reg.idle_armed <= 1'b0;
    end else begin
      q_reg <= q_next;
    end
  end

  // Bus answer and mode outputs
  assign avs_waitrequest = req & ~q_reg.ack;
  assign avs_readdata = q_reg.rdata;
  assign host_mode = q_reg.ctrl[UOEF_HOST_BIT];
  assign suspend_req = q_reg.ctrl[UOEF_SUSP_BIT];

  // One level interrupt from both banks
  assign irq = otg_irq | err_irq;

endmodule
`default_nettype wire

/* hdl/uoef_pkg.sv */
// Constants and carrier types for the OTG event flag block.
// Assumes a 20 MHz ref_clk and a 32-bit register bus.
package uoef_pkg;

  // Clock and timing
  localparam int UOEF_CLK_NS = 50;
  localparam int UOEF_MS_NS = 1000000;
  localparam int UOEF_MS_CYCLES = UOEF_MS_NS / UOEF_CLK_NS;
  localparam int UOEF_IDLE_BIT_TIMES = 16;

  // Register byte offsets
  localparam logic [4:0] UOEF_OFF_OTG_STAT = 5'h00;
  localparam logic [4:0] UOEF_OFF_OTG_MASK = 5'h04;
  localparam logic [4:0] UOEF_OFF_ERR_STAT = 5'h08;
  localparam logic [4:0] UOEF_OFF_ERR_MASK = 5'h0C;
  localparam logic [4:0] UOEF_OFF_CTRL = 5'h10;
  localparam logic [4:0] UOEF_OFF_LINE = 5'h14;

  // Event status field positions
  localparam int UOEF_ID_BIT = 7;
  localparam int UOEF_MS_BIT = 6;
  localparam int UOEF_LSTATE_BIT = 5;
  localparam int UOEF_ACT_BIT = 4;
  localparam int UOEF_SESVD_BIT = 3;
  localparam int UOEF_BVBUS_BIT = 2;
  localparam int UOEF_AVBUS_BIT = 0;
  localparam logic [7:0] UOEF_OTG_IMPL = 8'hFD;

  // Error status field positions
  localparam int UOEF_PID_BIT = 0;
  localparam int UOEF_CRC_EOF_BIT = 1;
  localparam int UOEF_TMO_BIT = 4;
  localparam int UOEF_DMA_BIT = 5;
  localparam logic [7:0] UOEF_ERR_IMPL = 8'h33;

  // Control fields
  localparam int UOEF_HOST_BIT = 0;
  localparam int UOEF_SUSP_BIT = 1;
  localparam logic [7:0] UOEF_CTRL_IMPL = 8'h03;

  // Reset values
  localparam logic [7:0] UOEF_FLAGS_RST = 8'h00;
  localparam logic [7:0] UOEF_MASK_RST = 8'h00;
  localparam logic [7:0] UOEF_CTRL_RST = 8'h00;
  localparam logic [1:0] UOEF_LS_RST = 2'h0;

  // Sampled cable side levels
  typedef struct packed {
    logic id;
    logic dp;
    logic dm;
    logic sess_end;
    logic sess_vld;
  } uoef_pins_t;

  // Events from the packet engine and DMA
  typedef struct packed {
    logic crc5_bad;
    logic sof_zero;
    logic xfer_busy;
    logic pid_bad;
    logic dma_ovf;
    logic dma_unf;
    logic rx_trunc;
    logic bit_tick;
    logic eop;
    logic resp_wait;
  } uoef_link_t;

endpackage

/* hdl/uoef_flag_bank.sv */
// Bank of eight sticky flags, write one to clear, with interrupt mask.
// Assumes set pulses and clear strobes are synchronous to clk.
`timescale 1ns/10ps
`default_nettype none
module uoef_flag_bank
  import uoef_pkg::*;
#(
  parameter logic [7:0] IMPL = 8'hFF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Hardware events
  input wire logic [7:0] set_in,
  // Software clear
  input wire logic clr_we,
  input wire logic [7:0] clr_data,
  // Interrupt gating
  input wire logic [7:0] mask,
  output logic [7:0] flags,
  output logic irq
);

  typedef struct packed {
    logic [7:0] flags_reg;
  } uoef_bank_t;

  uoef_bank_t q_reg;
  uoef_bank_t q_next;

  // Per implemented bit: set beats a clear in the same cycle
  always_comb begin
    q_next = q_reg;
    for (int i = 0; i < 8; i++) begin
      if (!IMPL[i]) begin
        q_next.flags_reg[i] = 1'b0;
      end else if (set_in[i]) begin
        q_next.flags_reg[i] = 1'b1;
      end else if (clr_we && clr_data[i]) begin
        q_next.flags_reg[i] = 1'b0;
      end
    end
  end

  // State register, cleared at power-on
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_reg.flags_reg <= UOEF_FLAGS_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  assign flags = q_reg.flags_reg;
  assign irq = |(q_reg.flags_reg & mask);

endmodule
`default_nettype wire

/* bench/uoef_cable_model.sv */
// Cable partner model: holds the levels it puts on the cable pins.
// Assumes drive is called from the bench's main process.
`timescale 1ns/10ps
`default_nettype none
module uoef_cable_model
  import uoef_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Cable levels
  output uoef_pins_t pins
);
  // Levels start low and change just after a rising edge
  initial pins = '0;
  task automatic drive(input logic [4:0] p);
    @(posedge ref_clk);
    pins <= uoef_pins_t'(p);
  endtask
endmodule
`default_nettype wire

/* bench/uoef_event_flags_asserts.sv */
// Checker for the event flag block, bound to its top module.
// Assumes the bus master keeps to the one-wait-cycle handshake.
`timescale 1ns/10ps
`default_nettype none
module uoef_ef_asserts
  import uoef_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Cable and link
  input wire uoef_pins_t pins,
  input wire uoef_link_t link,
  // Outputs
  input wire logic host_mode,
  input wire logic suspend_req,
  input wire logic irq
);
  logic [7:0] om_reg;
  logic [7:0] em_reg;
  logic prim_reg;
  logic acc;
  logic wr0;
  assign acc = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr0 = avs_write & acc & avs_byteenable[0];
  // Mirror of both mask registers, so irq can be tied to its cause
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      om_reg <= 8'h00;
      em_reg <= 8'h00;
      prim_reg <= 1'b0;
    end else begin
      prim_reg <= 1'b1;
      if (wr0 && avs_address == UOEF_OFF_OTG_MASK) begin
        om_reg <= avs_writedata[7:0];
      end
      if (wr0 && avs_address == UOEF_OFF_ERR_MASK) begin
        em_reg <= avs_writedata[7:0];
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wait_first_a:
    assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
      |-> avs_waitrequest) else $error("request answered without wait");
  upper_zero_a:
    assert property (avs_read && acc |-> avs_readdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
  otg_bit1_a:
    assert property (avs_read && acc && avs_address == UOEF_OFF_OTG_STAT
      |-> !avs_readdata[1]) else $error("event bit 1 reads one");
  irq_fall_a:
    assert property ($fell(irq) |-> $past(avs_write && acc))
      else $error("irq fell without a write");
  mode_hold_a:
    assert property (!$stable(host_mode) |-> $past(wr0 && avs_address == UOEF_OFF_CTRL))
      else $error("host mode moved without write");
  id_irq_a:
    assert property (prim_reg && pins.id != $past(pins.id) && om_reg[7] |=> irq)
      else $error("id change gave no irq");
  pid_irq_a:
    assert property (link.pid_bad && em_reg[0] |=> irq) else $error("pid error gave no irq");
  crc_irq_a:
    assert property (link.crc5_bad && !host_mode && em_reg[1] |=> irq)
      else $error("crc error gave no irq");
  eof_irq_a:
    assert property (link.sof_zero && link.xfer_busy && host_mode && em_reg[1] |=> irq)
      else $error("frame error gave no irq");
  dma_irq_a:
    assert property ((link.dma_ovf || link.dma_unf || link.rx_trunc) && em_reg[5] |=> irq)
      else $error("dma error gave no irq");
  // Main scenarios reached
  cover property (avs_read && acc);
  cover property (link.pid_bad && em_reg[0]);
  cover property ($fell(irq));
endmodule
bind uoef_event_flags uoef_ef_asserts u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(pins),
  .link(link), .host_mode(host_mode), .suspend_req(suspend_req), .irq(irq));
`default_nettype wire

/* bench/usb_otg_event_flags_tb.sv */
// Bench for the event flag block: bus tasks and one task per scenario.
// Assumes the cable model drives pins and the bench drives link events.
`timescale 1ns/10ps
`default_nettype none
module usb_otg_event_flags_tb import uoef_pkg::*;;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] a = 5'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdata;
  logic wt, host, susp, irq;
  uoef_pins_t pins;
  uoef_link_t lk = '0;
  int bad_count = 0;
  int compares = 0;
  always #25 ref_clk = ~ref_clk;
  uoef_cable_model cable (.ref_clk(ref_clk), .pins(pins));
  uoef_event_flags #(.MS_CYC(20)) uut (.ref_clk(ref_clk), .rstn(rstn), .avs_address(a),
    .avs_read(rd), .avs_write(wr), .avs_byteenable(be), .avs_writedata(wd),
    .avs_readdata(rdata), .avs_waitrequest(wt), .pins(pins), .link(lk),
    .host_mode(host), .suspend_req(susp), .irq(irq));
  task automatic complete_run;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] b, input logic [4:0] ad,
                     input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge ref_clk);
    rd <= !w;
    wr <= w;
    be <= b;
    a <= ad;
    wd <= d;
    // Waitrequest and read data are taken at the rising edge itself
    do begin
      @(posedge ref_clk);
      n++;
    end while (wt !== 1'b0 && n < 50);
    if (n >= 50) begin
      bad_count++;
      complete_run();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic w(input logic [4:0] ad, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, 4'hF, ad, {24'h0, d}, q);
  endtask
  task automatic rc(input string n, input logic [4:0] ad, input logic [31:0] m,
                    input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, 4'hF, ad, 32'h0, q);
    chk(n, e, q & m);
  endtask
  task automatic ci(input logic e);
    @(negedge ref_clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic pulse(input logic [9:0] l);
    @(posedge ref_clk);
    lk <= uoef_link_t'(l);
    @(posedge ref_clk);
    lk <= '0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      lk <= uoef_link_t'(10'h005);
      @(posedge ref_clk);
      lk <= uoef_link_t'(10'h001);
    end
  endtask
  task automatic pin_case(input logic [4:0] p, input logic [7:0] e);
    w(UOEF_OFF_OTG_STAT, 8'hFF);
    cable.drive(p);
    repeat (2) @(posedge ref_clk);
    rc("otg flags", UOEF_OFF_OTG_STAT, 32'h9F, {24'h0, e});
  endtask
  task automatic err_case(input logic h, input logic [9:0] l, input logic [7:0] e);
    w(UOEF_OFF_CTRL, {7'h00, h});
    w(UOEF_OFF_ERR_STAT, 8'hFF);
    chk("host mode", {31'h0, h}, {31'h0, host});
    pulse(l);
    rc("err flags", UOEF_OFF_ERR_STAT, 32'hFF, {24'h0, e});
  endtask
  task automatic t_reset;
    logic [31:0] q;
    rc("otg stat", UOEF_OFF_OTG_STAT, 32'hFFFFFFFF, 32'h0);
    rc("err stat", UOEF_OFF_ERR_STAT, 32'hFFFFFFFF, 32'h0);
    rc("unmapped", 5'h1C, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, 4'hF, UOEF_OFF_OTG_STAT, 32'hFFFFFFFF, q);
    rc("otg unused", UOEF_OFF_OTG_STAT, 32'hFFFFFF9F, 32'h0);
    w(UOEF_OFF_OTG_MASK, 8'h80);
    w(UOEF_OFF_ERR_MASK, 8'h33);
  endtask
  task automatic t_pins;
    pin_case(5'h10, 8'h80);
    pin_case(5'h12, 8'h0C);
    pin_case(5'h10, 8'h04);
    pin_case(5'h11, 8'h01);
    pin_case(5'h19, 8'h00);
    w(UOEF_OFF_CTRL, 8'h02);
    rc("ctrl", UOEF_OFF_CTRL, 32'hFF, 32'h02);
    chk("suspend", 32'h1, {31'h0, susp});
    pin_case(5'h11, 8'h10);
    w(UOEF_OFF_CTRL, 8'h00);
  endtask
  task automatic t_line;
    repeat (25) @(posedge ref_clk);
    w(UOEF_OFF_OTG_STAT, 8'hFF);
    cable.drive(5'h15);
    repeat (8) @(posedge ref_clk);
    rc("line early", UOEF_OFF_OTG_STAT, 32'h20, 32'h00);
    repeat (10) @(posedge ref_clk);
    rc("line stable", UOEF_OFF_OTG_STAT, 32'h20, 32'h20);
    rc("line status", UOEF_OFF_LINE, 32'hFF, 32'h35);
    w(UOEF_OFF_OTG_STAT, 8'h40);
    repeat (21) @(posedge ref_clk);
    rc("ms tick", UOEF_OFF_OTG_STAT, 32'h40, 32'h40);
  endtask
  task automatic t_err;
    err_case(1'b0, 10'h040, 8'h01);
    err_case(1'b0, 10'h200, 8'h02);
    err_case(1'b1, 10'h200, 8'h00);
    err_case(1'b1, 10'h180, 8'h02);
    err_case(1'b1, 10'h100, 8'h00);
    err_case(1'b0, 10'h180, 8'h00);
    err_case(1'b0, 10'h020, 8'h20);
    err_case(1'b1, 10'h010, 8'h20);
    err_case(1'b0, 10'h008, 8'h20);
    w(UOEF_OFF_CTRL, 8'h00);
  endtask
  task automatic t_tmo;
    w(UOEF_OFF_ERR_STAT, 8'hFF);
    @(posedge ref_clk);
    lk <= uoef_link_t'(10'h003);
    ticks(16);
    rc("idle 16", UOEF_OFF_ERR_STAT, 32'hFF, 32'h00);
    ticks(1);
    rc("idle 17", UOEF_OFF_ERR_STAT, 32'hFF, 32'h10);
    @(posedge ref_clk);
    lk <= '0;
  endtask
  task automatic t_w1c;
    logic [31:0] q;
    err_case(1'b0, 10'h040, 8'h01);
    w(UOEF_OFF_ERR_STAT, 8'h00);
    rc("write zero", UOEF_OFF_ERR_STAT, 32'hFF, 32'h01);
    bus(1'b1, 4'h0, UOEF_OFF_ERR_STAT, 32'h01, q);
    rc("no lane", UOEF_OFF_ERR_STAT, 32'hFF, 32'h01);
    // PID error present only at the edge that accepts the clearing write
    fork
      w(UOEF_OFF_ERR_STAT, 8'h01);
      begin
        repeat (2) @(posedge ref_clk);
        lk <= uoef_link_t'(10'h040);
        @(posedge ref_clk);
        lk <= '0;
      end
    join
    rc("set wins", UOEF_OFF_ERR_STAT, 32'hFF, 32'h01);
    w(UOEF_OFF_ERR_STAT, 8'h01);
    rc("cleared", UOEF_OFF_ERR_STAT, 32'hFF, 32'h00);
  endtask
  // Interrupt raised, masked, unmasked and cleared
  task automatic t_irq;
    w(UOEF_OFF_OTG_MASK, 8'h00);
    w(UOEF_OFF_ERR_MASK, 8'h01);
    ci(1'b0);
    pulse(10'h040);
    ci(1'b1);
    w(UOEF_OFF_ERR_MASK, 8'h00);
    ci(1'b0);
    w(UOEF_OFF_ERR_MASK, 8'h01);
    ci(1'b1);
    w(UOEF_OFF_ERR_STAT, 8'h01);
    ci(1'b0);
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_pins();
    t_line();
    t_err();
    t_tmo();
    t_w1c();
    t_irq();
    complete_run();
  end
endmodule
`default_nettype wire
